//--- logic/wiper_preset_tolerance_store.sv
`include "wiper_cfg.svh"
module wiper_preset_tolerance_store
  import wiper_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  input wire logic [`OTP_LOC_W-1:0] otp_last_loc_i,
  input wire logic [`WIPER_W-1:0] otp_rd_data_i,
  output logic [`OTP_LOC_W-1:0] otp_rd_addr_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  output logic [`WIPER_W-1:0] wiper_code_o,
  output logic [`TAP_COUNT-1:0] tap_sel_o,
  output logic preset_done_o
);
  // pin synchronisers
  logic [1:0] sclk_s_q, sync_s_q, din_s_q;
  logic sclk_d1_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s_q <= 2'h0;
      sync_s_q <= 2'h3;
      din_s_q <= 2'h0;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      sync_s_q <= {sync_s_q[0], sync_n_i};
      din_s_q <= {din_s_q[0], din_i};
      sclk_d1_q <= sclk_s_q[1];
    end
  end
  wire sclk_fall = sclk_d1_q & ~sclk_s_q[1];
  wire sclk_rise = ~sclk_d1_q & sclk_s_q[1];
  wire sync_n = sync_s_q[1];
  wire frame_end;

  // factory tolerance words, constants only
  localparam word_t TOL_HI = `TOL_HI_INIT;
  localparam word_t TOL_LO = `TOL_LO_INIT;
  function automatic word_t tol_word(input logic [`OTP_LOC_W-1:0] a);
    if (a == `TOL_HI_LOC) tol_word = {2'h0, TOL_HI[7:0]};
    else tol_word = {2'h0, TOL_LO[7:0]};
  endfunction

  // power-on preset
  preset_state_t st_q, st_d;
  logic [`WIPER_W-1:0] wiper_q, wiper_d;
  logic unlock_q;
  logic [15:0] shin_q;
  logic [4:0] cnt_q;
  // decode includes the bit arriving on the closing edge
  wire [15:0] shin_nx = {shin_q[14:0], din_s_q[1]};
  wire [3:0] cmd = shin_nx[13:10];
  wire [9:0] dat = shin_nx[9:0];
  wire unlock_bit = dat[`UNLOCK_BIT];
  wire [`OTP_LOC_W-1:0] dat_loc = dat[`OTP_LOC_W-1:0];
  wire loaded = (otp_last_loc_i != '0) && (otp_last_loc_i <= `OTP_LAST_LOC);
  always_comb begin
    st_d = st_q;
    case (st_q)
      PRESET_MID: st_d = loaded ? PRESET_SCAN : PRESET_DONE;
      PRESET_SCAN: st_d = PRESET_DONE;
      default: st_d = PRESET_DONE;
    endcase
  end
  wire wr_ok = frame_end && cmd == `CMD_WR_WIPER && unlock_q;
  always_comb begin
    wiper_d = wiper_q;
    if (st_q == PRESET_SCAN) wiper_d = otp_rd_data_i;
    else if (st_q == PRESET_DONE && wr_ok) wiper_d = dat;
  end

  // serial frame capture
  assign frame_end = sclk_fall && cnt_q == `FRAME_BITS - 5'h1 && !sync_n;
  logic [`OTP_LOC_W-1:0] rd_loc_q;
  logic [15:0] shout_q;
  logic oe_q;
  logic sdo_q;
  wire shout_msb = shout_q[15];
  word_t rd_word;
  wire is_tol = rd_loc_q == `TOL_HI_LOC || rd_loc_q == `TOL_LO_LOC;
  assign rd_word = is_tol ? tol_word(rd_loc_q) : otp_rd_data_i;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= PRESET_MID;
      wiper_q <= `WIPER_MID;
      unlock_q <= 1'b0;
      shin_q <= 16'h0000;
      cnt_q <= 5'h00;
      rd_loc_q <= '0;
      shout_q <= 16'h0000;
      oe_q <= 1'b0;
      sdo_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wiper_q <= wiper_d;
      if (sync_n) cnt_q <= 5'h00;
      else if (sclk_fall) begin
        shin_q <= shin_nx;
        cnt_q <= frame_end ? 5'h00 : cnt_q + 5'h01;
      end
      // each rising edge presents the next bit, msb first
      if (sclk_rise && !sync_n) begin
        sdo_q <= shout_msb;
        shout_q <= {shout_q[14:0], 1'b0};
      end else if (sync_n) sdo_q <= 1'b1;
      if (frame_end) begin
        if (cmd == `CMD_RD_OTP) begin
          rd_loc_q <= dat_loc;
          oe_q <= 1'b1;
        end else oe_q <= 1'b0;
        if (cmd == `CMD_WR_CTRL) unlock_q <= unlock_bit;
      end else if (oe_q && sync_n) begin
        shout_q <= {6'h00, rd_word};
      end
    end
  end
  // read address is otp_last_loc_i until preset done, then rd_loc_q
  assign otp_rd_addr_o = (st_q == PRESET_DONE) ? rd_loc_q : otp_last_loc_i;
  assign serial_data_out_o = sdo_q;
  assign serial_data_out_oe_o = oe_q & ~sdo_q;
  assign wiper_code_o = wiper_q;
  assign preset_done_o = st_q == PRESET_DONE;

  tap_decoder u_dec (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .code_i(wiper_q),
    .tap_sel_o(tap_sel_o)
  );

  // preset sequence
  property p_midreset;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q == PRESET_MID && !loaded |=> wiper_q == `WIPER_MID;
  endproperty
  a_midreset: assert property (p_midreset)
    else $error("midscale lost");

  property p_blank;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && st_q == PRESET_MID && !loaded |=> st_q == PRESET_DONE;
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank preset not done");

  property p_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q == PRESET_SCAN |=> wiper_q == $past(otp_rd_data_i);
  endproperty
  a_load: assert property (p_load)
    else $error("preset load wrong");

  property p_scan_addr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q != PRESET_DONE |-> otp_rd_addr_o == otp_last_loc_i;
  endproperty
  a_scan_addr: assert property (p_scan_addr)
    else $error("preset reads wrong location");

  // a loaded store passes through PRESET_SCAN, so allow up to two cycles
  property p_done;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i && st_q == PRESET_MID |-> ##[1:2] st_q == PRESET_DONE;
  endproperty
  a_done: assert property (p_done)
    else $error("preset stuck");

  // wiper write protection
  property p_lock;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q == PRESET_DONE && !unlock_q |=> $stable(wiper_q);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked wiper moved");

  property p_wr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_ok && st_q == PRESET_DONE |=> wiper_q == $past(dat);
  endproperty
  a_wr: assert property (p_wr)
    else $error("unlocked write lost");

  property p_unlock;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    frame_end && cmd == `CMD_WR_CTRL |=> unlock_q == $past(unlock_bit);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock bit not taken");

  // tolerance words
  property p_tolhi;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_loc_q == `TOL_HI_LOC |-> rd_word[9:8] == 2'h0
    && rd_word[`TOL_SIGN_BIT] == TOL_HI[7];
  endproperty
  a_tolhi: assert property (p_tolhi)
    else $error("tol hi wrong");

  property p_tolint;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_loc_q == `TOL_HI_LOC |-> rd_word[6:0] == TOL_HI[6:0];
  endproperty
  a_tolint: assert property (p_tolint)
    else $error("tol int wrong");

  property p_tollo;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_loc_q == `TOL_LO_LOC |-> rd_word == {2'h0, TOL_LO[7:0]};
  endproperty
  a_tollo: assert property (p_tollo)
    else $error("tol frac wrong");

  // readback path
  property p_out;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    frame_end && cmd == `CMD_RD_OTP |=> oe_q;
  endproperty
  a_out: assert property (p_out)
    else $error("readback not armed");

  property p_oe_off;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    frame_end && cmd != `CMD_RD_OTP |=> !oe_q;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("readback left armed");

  property p_rd_loc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    frame_end && cmd == `CMD_RD_OTP |=> rd_loc_q == $past(dat_loc);
  endproperty
  a_rd_loc: assert property (p_rd_loc)
    else $error("read location not taken");

  property p_load_word;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    oe_q && sync_n |=> shout_q == {6'h00, $past(rd_word)};
  endproperty
  a_load_word: assert property (p_load_word)
    else $error("readback word not loaded");

  property p_shift;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    sclk_rise && !sync_n |=> serial_data_out_o == $past(shout_msb);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial out bit wrong");

  c_load: cover property (@(posedge sys_clk_i) st_q == PRESET_SCAN);
  c_wr: cover property (@(posedge sys_clk_i) wr_ok);
  c_rd: cover property (@(posedge sys_clk_i) frame_end && is_tol);
endmodule

//--- include/wiper_cfg.svh
`ifndef WIPER_CFG_SVH
`define WIPER_CFG_SVH
`define WIPER_W 10
`define TAP_COUNT 1024
`define WIPER_MID 10'h200
`define OTP_LOC_W 6
`define OTP_LAST_LOC 6'h32
`define TOL_HI_LOC 6'h39
`define TOL_LO_LOC 6'h3A
`define TOL_SIGN_BIT 7
`define FRAME_BITS 5'h10
`define CMD_NOP 4'h0
`define CMD_WR_WIPER 4'h1
`define CMD_RD_WIPER 4'h2
`define CMD_STORE 4'h3
`define CMD_RD_OTP 4'h5
`define CMD_RD_CTRL 4'h8
`define CMD_WR_CTRL 4'h7
`define UNLOCK_BIT 1
`define TOL_HI_INIT 10'h00A
`define TOL_LO_INIT 10'h0B0
`endif

//--- include/wiper_pkg.sv
package wiper_pkg;
  typedef enum logic [1:0] {
    PRESET_MID = 2'b00,
    PRESET_SCAN = 2'b01,
    PRESET_DONE = 2'b10
  } preset_state_t;
  typedef logic [9:0] word_t;
endpackage

//--- logic/tap_decoder.sv
`include "wiper_cfg.svh"
module tap_decoder
  import wiper_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`WIPER_W-1:0] code_i,
  output logic [`TAP_COUNT-1:0] tap_sel_o
);
  logic [`TAP_COUNT-1:0] tap_d;
  logic [`TAP_COUNT-1:0] tap_q;
  wire [`TAP_COUNT-1:0] tap_one = {{(`TAP_COUNT-1){1'b0}}, 1'b1};
  assign tap_d = {{(`TAP_COUNT-1){1'b0}}, 1'b1} << code_i;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tap_q <= '0;
    else tap_q <= tap_d;
  end
  assign tap_sel_o = tap_q;
  // first sample after release still sees the reset value
  property p_onehot;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i |=> $onehot(tap_q);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("tap not one-hot");
  property p_tap_match;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i |=> tap_q == (tap_one << $past(code_i));
  endproperty
  a_tap_match: assert property (p_tap_match)
    else $error("tap does not follow code");
endmodule

//--- tb/serial_host_model.sv
module serial_host_model (
  input wire logic sys_clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up holds the line high while released
  wire logic line = sdo_oe_i ? sdo_i : 1'b1;
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end
  // one 16-bit frame, msb first, sclk idle low outside frames
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    @(posedge sys_clk_i) sync_n_o <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    for (i = 15; i >= 0; i--) begin
      sclk_o <= 1'b1;
      din_o <= tx[i];
      repeat (10) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
      rx[i] = line;
      repeat (10) @(posedge sys_clk_i);
    end
    sync_n_o <= 1'b1;
    din_o <= ~din_o;
    repeat (20) @(posedge sys_clk_i);
  endtask
endmodule

//--- tb/wiper_preset_tolerance_store_tb.sv
`include "wiper_cfg.svh"
module wiper_preset_tolerance_store_tb;
  import wiper_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam word_t TOL_HI = `TOL_HI_INIT;
  localparam word_t TOL_LO = `TOL_LO_INIT;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] last_loc = 6'h00;
  logic [5:0] rd_addr;
  logic serial_data_out, sdo_oe, preset_done, sclk, sync_n, din;
  word_t store [64];
  word_t wiper;
  logic [1023:0] tap;
  logic [15:0] rx, hi;
  word_t d;
  int i, loc;
  int miscompares = 0;
  int num_checks = 0;
  wire word_t rd_data = store[rd_addr];
  always #2.5 sys_clk = ~sys_clk;
  wiper_preset_tolerance_store i_wiper_preset_tolerance_store (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sclk_i(sclk),
    .sync_n_i(sync_n), .din_i(din), .otp_last_loc_i(last_loc),
    .otp_rd_data_i(rd_data), .otp_rd_addr_o(rd_addr),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
    .wiper_code_o(wiper), .tap_sel_o(tap), .preset_done_o(preset_done));
  serial_host_model i_serial_host_model (
    .sys_clk_i(sys_clk), .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe), .sclk_o(sclk),
    .sync_n_o(sync_n), .din_o(din));
  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(string what, logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] fr(logic [3:0] c, word_t v);
    return {2'b00, c, v};
  endfunction
  task do_reset(logic [5:0] l);
    int n;
    @(posedge sys_clk) rst_n <= 1'b0;
    last_loc <= l;
    repeat (16) @(posedge sys_clk);
    check("rst_wiper", 16'(wiper), 16'(`WIPER_MID));
    rst_n <= 1'b1;
    n = 0;
    while (preset_done !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 100) begin
      miscompares++;
      end_sim;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task rd(logic [5:0] a);
    i_serial_host_model.frame(fr(`CMD_RD_OTP, {4'h0, a}), rx);
    i_serial_host_model.frame(16'h0000, rx);
    check("lead", 16'(rx[15:10]), 16'h0000);
  endtask
  task tol_check;
    rd(`TOL_HI_LOC);
    hi = rx;
    check("sign", 16'(rx[7]), 16'(TOL_HI[7]));
    check("int", 16'(rx[6:0]), 16'(TOL_HI[6:0]));
    rd(`TOL_LO_LOC);
    check("frac", 16'(rx[7:0]), 16'(TOL_LO[7:0]));
    check("tol", {hi[7:0], rx[7:0]}, {TOL_HI[7:0], TOL_LO[7:0]});
  endtask
  initial begin
    void'($urandom(32'h3C4441DA));
    foreach (store[k]) store[k] = word_t'($urandom);
    do_reset(6'h00);
    check("blank", 16'(wiper), 16'(`WIPER_MID));
    check("tap0", 16'(tap === (1024'(1) << `WIPER_MID)), 16'h1);
    $display("test blank preset done");
    loc = 1 + $urandom_range(49);
    do_reset(6'(loc));
    check("preset", 16'(wiper), 16'(store[loc]));
    d = ~store[loc];
    i_serial_host_model.frame(fr(`CMD_WR_WIPER, d), rx);
    check("locked", 16'(wiper), 16'(store[loc]));
    tol_check;
    $display("test locked and tolerance done");
    i_serial_host_model.frame(fr(`CMD_WR_CTRL, 10'h002), rx);
    for (i = 0; i < 6; i++) begin
      d = i == 0 ? 10'h000 : i == 1 ? 10'h3FF : word_t'($urandom);
      i_serial_host_model.frame(fr(`CMD_WR_WIPER, d), rx);
      check("wr", 16'(wiper), 16'(d));
      check("tap", 16'(tap === (1024'(1) << d)), 16'h1);
    end
    i_serial_host_model.frame(fr(`CMD_STORE, 10'h039), rx);
    tol_check;
    loc = 1 + $urandom_range(49);
    rd(6'(loc));
    check("otp", 16'(rx[9:0]), 16'(store[loc]));
    $display("test unlocked writes and readback done");
    end_sim;
  end
endmodule
